// [design/hcpti_match.sv]
// hcpti_match: masked compare of a buffer write against the trigger address/data.
// assumes buffer writes arrive as a one-cycle strobe with address and data.
`timescale 1ns/1ps
module hcpti_match (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// trigger set-up
	input wire logic [15:0] trigAddr,
	input wire logic [7:0] trigData,
	input wire logic [7:0] trigMask,
	// buffer write observation
	input wire logic bufWrStb,
	input wire logic [15:0] bufWrAddr,
	input wire logic [7:0] bufWrData,
	// one-cycle hit pulse
	output logic hit
);
	import hcpti_pkg::*;
	logic [7:0] diff;
	assign diff = (bufWrData ^ trigData) & trigMask;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hit <= 1'b0;
		end else begin
			hit <= bufWrStb && (bufWrAddr == trigAddr) && (diff == 8'h00);
		end
	end
endmodule // hcpti_match

// [design/hcpti_port.sv]
// hcpti_port: host command interpreter for trigger, attention mask, terminal type and identity readback.
// assumes the host bus gives one-cycle read/write strobes with a 12-bit i/o address and byte data;
// the coax side reports status-bit sets and buffer writes, and takes a power-on-reset request pulse.
// limitation: only the low four bits of a command write are decoded; the upper bits are dropped.
// the host is expected to write the command code before its parameter bytes.
//
// How it works
// - cmd 8 loads trigger address low, high
// - masked buffer match sets match flag
// - trigger address command clears match flag
// - cmd 9 stores attention mask byte
// - masked status rise sets attention request
// - cmd A stores terminal type identifier
// - changed terminal type starts power-on reset
// - codes B, D, F do nothing
// - cmd C returns page numbers, terminal id
// - cmd E returns BCD revision, OEM
// - clear-status mask clears match flag
// - compare only masked trigger bits
`timescale 1ns/1ps
module hcpti_port (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// host i/o ports
	input wire logic ioWr,
	input wire logic ioRd,
	input wire logic [11:0] ioAddr,
	input wire logic [7:0] ioWrData,
	output logic [7:0] ioRdData,
	// status events from the coax side (one-cycle set pulses per bit)
	input wire logic [7:0] statusSet,
	// buffer writes seen by the trigger watcher
	input wire logic bufWrStb,
	input wire logic [15:0] bufWrAddr,
	input wire logic [7:0] bufWrData,
	// page numbers from the buffer manager
	input wire logic [7:0] eabPage,
	input wire logic [7:0] intPage,
	// outputs toward the coax side and host
	output logic [7:0] terminalId,
	output logic porRequest,
	output logic attnRequest,
	output logic [7:0] mainStatus
);
	import hcpti_pkg::*;

	// command latch and its decode
	logic [3:0] cmd_reg;
	logic isClrStatus;
	logic isTrigData;
	logic isTrigAddr;
	logic isAttnMask;
	logic isTermType;
	logic isTermInfo;
	logic isRevId;

	// host port strobes
	logic wrCmd;
	logic wrP1;
	logic wrP2;
	logic wrP3;
	logic rdCmd;
	logic rdP1;
	logic rdP2;
	logic rdP3;

	// parameter loads, one per command and port
	logic ldTrigData;
	logic ldTrigMask;
	logic ldTrigAddrLo;
	logic ldTrigAddrHi;
	logic ldAttnMask;
	logic ldTermType;
	logic ldClrMask;
	logic trigAddrCmd;

	// trigger set-up and hit
	logic [7:0] trigData_reg;
	logic [7:0] trigMask_reg;
	logic [15:0] trigAddr_reg;
	logic matchHit;

	// main status
	logic [7:0] clrMask;
	logic [7:0] setMask;
	logic [7:0] status_next;
	logic [7:0] rise;

	// attention
	logic [7:0] attnMask_reg;
	logic [7:0] attnHit;
	logic attnSet;

	// terminal type
	logic typeChanged;

	// read path
	logic [7:0] paramRd;
	logic [7:0] ioRdData_next;

	// address decode; an unmapped address strobes nothing, so its writes vanish and its reads give zero
	assign wrCmd = ioWr && (ioAddr == PORT_CMD);
	assign wrP1 = ioWr && (ioAddr == PORT_P1);
	assign wrP2 = ioWr && (ioAddr == PORT_P2);
	assign wrP3 = ioWr && (ioAddr == PORT_P3);
	assign rdCmd = ioRd && (ioAddr == PORT_CMD);
	assign rdP1 = ioRd && (ioAddr == PORT_P1);
	assign rdP2 = ioRd && (ioAddr == PORT_P2);
	assign rdP3 = ioRd && (ioAddr == PORT_P3);

	// decode of the latched command; the nop codes decode to nothing at all
	assign isClrStatus = (cmd_reg == CMD_CLR_STATUS);
	assign isTrigData = (cmd_reg == CMD_TRIG_DATA);
	assign isTrigAddr = (cmd_reg == CMD_TRIG_ADDR);
	assign isAttnMask = (cmd_reg == CMD_ATTN_MASK);
	assign isTermType = (cmd_reg == CMD_TERM_TYPE);
	assign isTermInfo = (cmd_reg == CMD_TERM_INFO);
	assign isRevId = (cmd_reg == CMD_REV_ID);

	// a parameter write counts only under the command that owns that port; others are ignored
	assign ldTrigData = isTrigData && wrP1;
	assign ldTrigMask = isTrigData && wrP2;
	assign ldTrigAddrLo = isTrigAddr && wrP1;
	assign ldTrigAddrHi = isTrigAddr && wrP2;
	assign ldAttnMask = isAttnMask && wrP3;
	assign ldTermType = isTermType && wrP3;
	assign ldClrMask = isClrStatus && wrP3;
	// the match flag drops as the command code itself lands, before any address byte
	assign trigAddrCmd = wrCmd && (ioWrData[3:0] == CMD_TRIG_ADDR);

	// trigger watcher: one-cycle hit the cycle after a matching buffer write
	hcpti_match hcpti_match_inst (
		.sys_clk(sys_clk),
		.rst(rst),
		.trigAddr(trigAddr_reg),
		.trigData(trigData_reg),
		.trigMask(trigMask_reg),
		.bufWrStb(bufWrStb),
		.bufWrAddr(bufWrAddr),
		.bufWrData(bufWrData),
		.hit(matchHit)
	);

	// command latch: a write to the command port selects what the parameter ports mean
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cmd_reg <= RST_CMD;
		end else if (wrCmd) begin
			cmd_reg <= ioWrData[3:0];
		end
	end

	// trigger data (cmd 7, first parameter port)
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			trigData_reg <= RST_BYTE;
		end else if (ldTrigData) begin
			trigData_reg <= ioWrData;
		end
	end

	// trigger mask (cmd 7, second parameter port); a zero mask makes every write to the address hit
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			trigMask_reg <= RST_BYTE;
		end else if (ldTrigMask) begin
			trigMask_reg <= ioWrData;
		end
	end

	// trigger address (cmd 8); the two bytes may come in either order
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			trigAddr_reg <= RST_ADDR;
		end else begin
			if (ldTrigAddrLo) begin
				trigAddr_reg[7:0] <= ioWrData;
			end
			if (ldTrigAddrHi) begin
				trigAddr_reg[15:8] <= ioWrData;
			end
		end
	end

	// attention mask (cmd 9)
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			attnMask_reg <= RST_BYTE;
		end else if (ldAttnMask) begin
			attnMask_reg <= ioWrData;
		end
	end

	// terminal type (cmd A)
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			terminalId <= TERM_TYPE_DEFAULT;
		end else if (ldTermType) begin
			terminalId <= ioWrData;
		end
	end

	// only a real change of type asks the coax side for the por response; a repeat is silent
	assign typeChanged = (ioWrData != terminalId);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			porRequest <= 1'b0;
		end else begin
			porRequest <= ldTermType && typeChanged;
		end
	end

	// clears from the host: the clear-status mask, and the match bit on the trigger-address command
	always_comb begin
		clrMask = 8'h00;
		if (ldClrMask) begin
			clrMask = ioWrData;
		end
		if (trigAddrCmd) begin
			clrMask[STAT_MATCH_BIT] = 1'b1;
		end
	end

	// sets: coax-side events, plus the trigger hit on the match bit
	always_comb begin
		setMask = statusSet;
		if (matchHit) begin
			setMask[STAT_MATCH_BIT] = 1'b1;
		end
	end

	// per-bit next value and rising edge; a set in the same cycle as a clear wins so no event is lost
	for (genvar b = 0; b < 8; b++) begin : g_status
		assign status_next[b] = setMask[b] || (mainStatus[b] && !clrMask[b]);
		assign rise[b] = status_next[b] && !mainStatus[b];
		assign attnHit[b] = rise[b] && attnMask_reg[b];
	end

	// main status register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mainStatus <= RST_BYTE;
		end else begin
			mainStatus <= status_next;
		end
	end

	// attention request is sticky; host clears it by rewriting the attention mask, and a new event wins
	assign attnSet = (attnHit != 8'h00);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			attnRequest <= 1'b0;
		end else if (attnSet) begin
			attnRequest <= 1'b1;
		end else if (ldAttnMask) begin
			attnRequest <= 1'b0;
		end
	end

	// parameter-port read data under the latched command; nop codes and unused ports read zero
	always_comb begin
		paramRd = RST_BYTE;
		if (isTermInfo) begin
			if (rdP1) begin
				paramRd = eabPage;
			end else if (rdP2) begin
				paramRd = intPage;
			end else if (rdP3) begin
				paramRd = terminalId;
			end
		end else if (isRevId) begin
			if (rdP1) begin
				paramRd = REVISION_BCD[7:0];
			end else if (rdP2) begin
				paramRd = REVISION_BCD[15:8];
			end else if (rdP3) begin
				paramRd = OEM_NUMBER;
			end
		end
	end

	// the command port returns main status whatever command is latched
	always_comb begin
		ioRdData_next = ioRdData;
		if (rdCmd) begin
			ioRdData_next = mainStatus;
		end else if (ioRd) begin
			ioRdData_next = paramRd;
		end
	end

	// read data registered: valid the cycle after the read strobe, held until the next one
	// trade-off: the register stage costs a cycle of latency but keeps the read byte free of glitches
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ioRdData <= RST_BYTE;
		end else begin
			ioRdData <= ioRdData_next;
		end
	end
endmodule // hcpti_port

// [shared/hcpti_pkg.sv]
// hcpti_pkg: constants for the host command port (trigger, attention, terminal type, identity).
// assumes a byte-wide host i/o port block decoded at 0x220..0x223.
package hcpti_pkg;
	// port addresses (all twelve i/o address bits compared by the port decode)
	localparam logic [11:0] PORT_CMD = 12'h0220;
	localparam logic [11:0] PORT_P1 = 12'h0221;
	localparam logic [11:0] PORT_P2 = 12'h0222;
	localparam logic [11:0] PORT_P3 = 12'h0223;
	// command codes
	localparam logic [3:0] CMD_CLR_STATUS = 4'h3;
	localparam logic [3:0] CMD_TRIG_DATA = 4'h7;
	localparam logic [3:0] CMD_TRIG_ADDR = 4'h8;
	localparam logic [3:0] CMD_ATTN_MASK = 4'h9;
	localparam logic [3:0] CMD_TERM_TYPE = 4'hA;
	localparam logic [3:0] CMD_NOP_B = 4'hB;
	localparam logic [3:0] CMD_TERM_INFO = 4'hC;
	localparam logic [3:0] CMD_NOP_D = 4'hD;
	localparam logic [3:0] CMD_REV_ID = 4'hE;
	localparam logic [3:0] CMD_NOP_F = 4'hF;
	// main status bit positions
	localparam int STAT_MATCH_BIT = 6;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_ADDR = 16'h0000;
	localparam logic [3:0] RST_CMD = 4'hB;
	// identity values: arbitrary, neutral
	localparam logic [15:0] REVISION_BCD = 16'h0100;
	localparam logic [7:0] OEM_NUMBER = 8'h00;
	localparam logic [7:0] TERM_TYPE_DEFAULT = 8'h02;
endpackage : hcpti_pkg

// [verif/hcpti_host.sv]
// hcpti_host: host software model on the byte-wide i/o ports.
// assumes the bench pops expQ one cycle after each read strobe.
`timescale 1ns/1ps
module hcpti_host (
	// clock
	input wire logic sys_clk,
	// host bus
	output logic ioWr,
	output logic ioRd,
	output logic [11:0] ioAddr,
	output logic [7:0] ioWrData
);
	import hcpti_pkg::*;
	logic [7:0] expQ[$];
	initial begin
		ioWr = 1'b0;
		ioRd = 1'b0;
		ioAddr = 12'h0000;
		ioWrData = 8'h00;
	end
	// an idle bus shows inverted values so stale data never looks valid
	task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		ioWr <= wr;
		ioRd <= !wr;
		ioAddr <= a;
		ioWrData <= d;
		if (!wr) expQ.push_back(d);
		@(posedge sys_clk);
		ioWr <= 1'b0;
		ioRd <= 1'b0;
		ioAddr <= ~a;
		ioWrData <= ~d;
	endtask
endmodule // hcpti_host

// [verif/hcpti_port_props.sv]
// hcpti_port_props: port-level checks of the host command port.
// assumes a bind onto hcpti_port and one sys_clk domain.
`timescale 1ns/1ps
module hcpti_port_props import hcpti_pkg::*; (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// host side
	input wire logic ioWr,
	input wire logic ioRd,
	input wire logic [11:0] ioAddr,
	input wire logic [7:0] ioWrData,
	input wire logic [7:0] ioRdData,
	// coax side
	input wire logic [7:0] statusSet,
	input wire logic bufWrStb,
	input wire logic [7:0] terminalId,
	input wire logic porRequest,
	input wire logic attnRequest,
	input wire logic [7:0] mainStatus
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_por_pulse: assert property (porRequest |=> !porRequest) else $error("por too long");
	a_por_diff: assert property (porRequest |-> !$stable(terminalId)) else $error("por on same type");
	a_type_por: assert property (!$stable(terminalId) |-> porRequest) else $error("type change no por");
	a_id_load: assert property (!$stable(terminalId) |-> $past(ioWr) && $past(ioAddr) == PORT_P3)
		else $error("id moved");
	a_status_read: assert property (ioRd && ioAddr == PORT_CMD |=> ioRdData == $past(mainStatus))
		else $error("status read wrong");
	a_rd_hold: assert property (!ioRd |=> $stable(ioRdData)) else $error("read data moved");
	a_attn_hold: assert property (attnRequest && !(ioWr && ioAddr == PORT_P3) |=> attnRequest)
		else $error("attention dropped");
	a_match_clr: assert property (ioWr && ioAddr == PORT_CMD && ioWrData[3:0] == CMD_TRIG_ADDR && !$past(bufWrStb)
		&& !statusSet[STAT_MATCH_BIT] |=> !mainStatus[STAT_MATCH_BIT]) else $error("match not cleared");
	c_por: cover property (porRequest);
	c_attn: cover property ($rose(attnRequest));
	c_match: cover property ($rose(mainStatus[STAT_MATCH_BIT]));
endmodule // hcpti_port_props
bind hcpti_port hcpti_port_props hcpti_port_props_inst (.sys_clk, .rst, .ioWr, .ioRd, .ioAddr, .ioWrData,
	.ioRdData, .statusSet, .bufWrStb, .terminalId, .porRequest, .attnRequest, .mainStatus);

// [verif/hcpti_port_tb_top.sv]
// hcpti_port_tb_top: self-checking bench for the host command port.
// assumes the host model drives the i/o ports; the bench drives the coax side.
`timescale 1ns/1ps
module hcpti_port_tb_top;
	import hcpti_pkg::*;
	logic sys_clk, rst, ioWr, ioRd, bufWrStb, porRequest, attnRequest;
	logic pend = 1'b0;
	logic [11:0] ioAddr;
	logic [7:0] ioWrData, ioRdData, statusSet, bufWrData, eabPage, intPage, terminalId, mainStatus, d, m;
	logic [15:0] bufWrAddr, ta;
	int nMismatch = 0, comparisons = 0, nPor = 0;
	hcpti_host hcpti_host_inst (.sys_clk(sys_clk), .ioWr(ioWr), .ioRd(ioRd), .ioAddr(ioAddr), .ioWrData(ioWrData));
	hcpti_port hcpti_port_inst (.sys_clk(sys_clk), .rst(rst), .ioWr(ioWr), .ioRd(ioRd), .ioAddr(ioAddr),
		.ioWrData(ioWrData), .ioRdData(ioRdData), .statusSet(statusSet), .bufWrStb(bufWrStb),
		.bufWrAddr(bufWrAddr), .bufWrData(bufWrData), .eabPage(eabPage), .intPage(intPage),
		.terminalId(terminalId), .porRequest(porRequest), .attnRequest(attnRequest), .mainStatus(mainStatus));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			nMismatch++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic w(input logic [11:0] a, input logic [7:0] v);
		hcpti_host_inst.acc(1'b1, a, v);
	endtask
	task automatic r(input logic [11:0] a, input logic [7:0] v);
		hcpti_host_inst.acc(1'b0, a, v);
	endtask
	task automatic cw(input logic [3:0] c, input logic [11:0] a, input logic [7:0] v);
		w(PORT_CMD, {4'h0, c});
		w(a, v);
	endtask
	// coax-side strobe, then time for the status update to land
	task automatic ev(input logic [7:0] s, input logic b, input logic [15:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		statusSet <= s;
		bufWrStb <= b;
		bufWrAddr <= a;
		bufWrData <= v;
		@(posedge sys_clk);
		statusSet <= 8'h00;
		bufWrStb <= 1'b0;
		bufWrData <= ~v;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, nMismatch);
		if (nMismatch == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		if (pend) chk("ioRdData", hcpti_host_inst.expQ.pop_front(), ioRdData);
		pend <= ioRd;
		if (porRequest === 1'b1) nPor <= nPor + 1;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		nMismatch++;
		print_verdict;
	end
	initial begin
		{rst, statusSet, bufWrStb, bufWrAddr, bufWrData} = {1'b1, 33'h0};
		void'($urandom(81860));
		eabPage <= 8'($urandom);
		intPage <= 8'($urandom);
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		w(PORT_CMD, {4'h0, CMD_TERM_INFO});
		r(PORT_P1, eabPage);
		r(PORT_P2, intPage);
		r(PORT_P3, TERM_TYPE_DEFAULT);
		w(PORT_CMD, {4'h0, CMD_REV_ID});
		r(PORT_P1, REVISION_BCD[7:0]);
		r(PORT_P2, REVISION_BCD[15:8]);
		r(PORT_P3, OEM_NUMBER);
		for (int i = 0; i < 3; i++) begin
			w(PORT_CMD, {4'h0, (i == 0) ? CMD_NOP_B : (i == 1) ? CMD_NOP_D : CMD_NOP_F});
			r(PORT_P1, 8'h00);
			r(PORT_CMD, 8'h00);
		end
		$display("test info done");
		cw(CMD_ATTN_MASK, PORT_P3, 8'h01);
		ev(8'h01, 1'b0, 16'h0000, 8'h00);
		chk("attnRequest", 8'h01, {7'h0, attnRequest});
		cw(CMD_CLR_STATUS, PORT_P3, 8'hFF);
		cw(CMD_ATTN_MASK, PORT_P3, 8'h01);
		ev(8'h02, 1'b0, 16'h0000, 8'h00);
		chk("attnRequest", 8'h00, {7'h0, attnRequest});
		r(PORT_CMD, 8'h02);
		cw(CMD_CLR_STATUS, PORT_P3, 8'hFF);
		$display("test attention done");
		d = 8'($urandom);
		m = 8'($urandom) | 8'h01;
		ta = 16'($urandom);
		cw(CMD_TRIG_DATA, PORT_P1, d);
		w(PORT_P2, m);
		cw(CMD_TRIG_ADDR, PORT_P1, ta[7:0]);
		w(PORT_P2, ta[15:8]);
		ev(8'h00, 1'b1, ta + 16'h0001, d);
		ev(8'h00, 1'b1, ta, d ^ 8'h01);
		r(PORT_CMD, 8'h00);
		ev(8'h00, 1'b1, ta, (d & m) | (~m & 8'($urandom)));
		r(PORT_CMD, 8'h40);
		chk("mainStatus", 8'h40, mainStatus);
		cw(CMD_CLR_STATUS, PORT_P3, 8'h40);
		r(PORT_CMD, 8'h00);
		ev(8'h00, 1'b1, ta, d);
		r(PORT_CMD, 8'h40);
		w(PORT_CMD, {4'h0, CMD_TRIG_ADDR});
		r(PORT_CMD, 8'h00);
		$display("test trigger done");
		cw(CMD_TERM_TYPE, PORT_P3, TERM_TYPE_DEFAULT);
		w(PORT_P3, 8'h35);
		repeat (2) @(posedge sys_clk);
		chk("nPor", 8'h01, 8'(nPor));
		chk("terminalId", 8'h35, terminalId);
		w(PORT_CMD, {4'h0, CMD_TERM_INFO});
		r(PORT_P3, 8'h35);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		r(PORT_P3, 8'h00);
		chk("terminalId", TERM_TYPE_DEFAULT, terminalId);
		$display("test type done");
		repeat (2) @(posedge sys_clk);
		print_verdict;
	end
endmodule // hcpti_port_tb_top
